/* File: design/iapfpc_top.sv */
// flash program control: address/data/control registers, unlock, write buffer, op launch
//
// Contract
// RQ1: 13-bit word address; high register holds bits 12..8, upper three read zero.
// RQ2: writing data0_low only stores it; buffer untouched.
// RQ3: writing data0_high loads both data bytes into buffer, then bumps address; the load here needs erase_write_enabled set.
// RQ4: writing one to erase_write_enabled does nothing; writing zero disables it.
// RQ5: only a successful unlock sets erase_write_enabled; zero means disabled.
// RQ6: mode 000 write, 001 erase, 011 read, 110 unlock; others reserved.
// RQ7: software unlocks before any erase or write.
// RQ8: setting unlock_trigger starts a timer; expiry clears the trigger.
// RQ9: software writes the key into data pairs one to three before expiry.
// RQ10: write_start launches write or erase; hardware clears it when done.
// RQ11: reads run only while read_enable is one.
// RQ12: read_start launches a single-word read; hardware clears it when done.
// RQ13: software never sets write_start, read_enable, read_start in one write.
// RQ14: processor is stalled while a launched operation runs.
// RQ15: software ensures stable sub clock and lets operations finish.
// RQ16: writing 55H to chip_reset_key pulses whole-chip reset; value is stored.
// RQ17: address increment stops at page word 11111b.
// RQ18: unlock needs mode 110, trigger set and the six key bytes.
// RQ19: write buffer clears itself when a write finishes.
// RQ20: unlock timer length is a parameter; late keys do not unlock.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
module iapfpc_top #(
    parameter int UNLOCK_TIME_NS = iapfpc_pkg::UNLOCK_TIME_NS_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    // flash array side
    output iapfpc_pkg::iapfpc_cmd_type flash_cmd,
    output logic flash_req,
    input wire logic flash_done,
    input wire logic [15:0] flash_rdata,
    input wire logic [4:0] buf_rd_idx,
    output logic [15:0] buf_rd_data,
    // system
    output logic cpu_stall,
    output logic chip_reset
);

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    // longest time: round down, never below one cycle
    localparam int UNLOCK_CYCLES_RAW = UNLOCK_TIME_NS / iapfpc_pkg::CLK_PERIOD_NS;
    localparam int UNLOCK_CYCLES = (UNLOCK_CYCLES_RAW < 1) ? 1 : UNLOCK_CYCLES_RAW;
    localparam logic [15:0] UNLOCK_LOAD = 16'(UNLOCK_CYCLES);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic is_prog_mode(input logic [2:0] m);
        is_prog_mode = (m == iapfpc_pkg::MODE_WRITE) || (m == iapfpc_pkg::MODE_ERASE);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } iapfpc_state_type;

    iapfpc_state_type state_r;
    logic [12:0] addr_r;
    logic [12:0] addr_nxt;
    logic [7:0] data_lo_r [iapfpc_pkg::DATA_PAIRS];
    logic [7:0] data_hi_r [iapfpc_pkg::DATA_PAIRS];
    logic ew_en_r;
    logic ew_en_nxt;
    logic [2:0] mode_r;
    logic [2:0] mode_nxt;
    logic trigger_r;
    logic trigger_nxt;
    logic [15:0] timer_r;
    logic write_start_r;
    logic write_start_nxt;
    logic read_enable_r;
    logic read_start_r;
    logic read_start_nxt;
    logic clear_write_buffer_r;
    logic clear_write_buffer_nxt;
    logic [7:0] chip_key_r;
    logic chip_reset_r;
    logic [5:0] key_seen_r;
    logic [5:0] key_seen_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rd_sel;
    logic [15:0] wbuf [iapfpc_pkg::BUF_DEPTH];
    logic [15:0] buf_rd_r;
    iapfpc_pkg::iapfpc_cmd_type cmd_r;
    iapfpc_pkg::iapfpc_cmd_type cmd_nxt;
    iapfpc_pkg::iapfpc_op_type op_nxt;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    wire wr_addr_low = reg_we && hit(reg_addr, iapfpc_pkg::OFS_ADDR_LOW);
    wire wr_addr_high = reg_we && hit(reg_addr, iapfpc_pkg::OFS_ADDR_HIGH);
    wire wr_d0l = reg_we && hit(reg_addr, iapfpc_pkg::OFS_DATA0_LOW);
    wire wr_d0h = reg_we && hit(reg_addr, iapfpc_pkg::OFS_DATA0_HIGH);
    wire wr_d1l = reg_we && hit(reg_addr, iapfpc_pkg::OFS_DATA1_LOW);
    wire wr_d1h = reg_we && hit(reg_addr, iapfpc_pkg::OFS_DATA1_HIGH);
    wire wr_d2l = reg_we && hit(reg_addr, iapfpc_pkg::OFS_DATA2_LOW);
    wire wr_d2h = reg_we && hit(reg_addr, iapfpc_pkg::OFS_DATA2_HIGH);
    wire wr_d3l = reg_we && hit(reg_addr, iapfpc_pkg::OFS_DATA3_LOW);
    wire wr_d3h = reg_we && hit(reg_addr, iapfpc_pkg::OFS_DATA3_HIGH);
    wire wr_ctrl = reg_we && hit(reg_addr, iapfpc_pkg::OFS_PROGRAM_CONTROL);
    wire wr_chip = reg_we && hit(reg_addr, iapfpc_pkg::OFS_CHIP_RESET_KEY);
    wire wr_bufc = reg_we && hit(reg_addr, iapfpc_pkg::OFS_BUFFER_CONTROL);
    wire [3:0] wr_lo_vec = {wr_d3l, wr_d2l, wr_d1l, wr_d0l};
    wire [3:0] wr_hi_vec = {wr_d3h, wr_d2h, wr_d1h, wr_d0h};

    // ----------------------------------------------------------------
    // word address
    // ----------------------------------------------------------------
    // RQ17 page saturation: tagging past the page end would corrupt the next page
    wire at_page_end = (addr_r[iapfpc_pkg::BUF_IDX_W-1:0] == iapfpc_pkg::PAGE_LAST);
    wire [12:0] addr_inc = at_page_end ? addr_r : addr_r + iapfpc_pkg::ADDR_STEP;
    // RQ1 address byte split
    assign addr_nxt = wr_addr_low ? {addr_r[12:8], reg_wdata} :
                      wr_addr_high ? {reg_wdata[iapfpc_pkg::ADDR_HIGH_W-1:0], addr_r[7:0]} :
                      wr_d0h ? addr_inc :
                      addr_r;

    // ----------------------------------------------------------------
    // unlock
    // ----------------------------------------------------------------
    wire trigger_start = wr_ctrl && reg_wdata[iapfpc_pkg::BIT_UNLOCK_TRIGGER] && !trigger_r;
    wire timer_expire = trigger_r && (timer_r == iapfpc_pkg::TIMER_LAST);
    wire [5:0] key_wr = {wr_d3h, wr_d2h, wr_d1h, wr_d3l, wr_d2l, wr_d1l};
    wire [5:0] key_match = {
        reg_wdata == iapfpc_pkg::KEY_DATA3_HIGH,
        reg_wdata == iapfpc_pkg::KEY_DATA2_HIGH,
        reg_wdata == iapfpc_pkg::KEY_DATA1_HIGH,
        reg_wdata == iapfpc_pkg::KEY_DATA3_LOW,
        reg_wdata == iapfpc_pkg::KEY_DATA2_LOW,
        reg_wdata == iapfpc_pkg::KEY_DATA1_LOW
    };
    // RQ20 only key writes inside the window count; a mismatch retracts the byte
    assign key_seen_nxt = trigger_start ? 6'h00 :
                          trigger_r ? ((key_seen_r & ~key_wr) | (key_wr & key_match)) :
                          key_seen_r;
    // RQ18 mode, trigger and full key
    // any key write that leaves all six bytes matched unlocks, so a disable inside the window sticks until the next matching key write
    wire unlock_ok = trigger_r && (mode_r == iapfpc_pkg::MODE_UNLOCK) && (&key_seen_nxt) &&
                     (|key_wr);

    // RQ8 trigger set by software, cleared by the timer
    assign trigger_nxt = timer_expire ? 1'b0 :
                         wr_ctrl ? reg_wdata[iapfpc_pkg::BIT_UNLOCK_TRIGGER] :
                         trigger_r;

    // RQ5 set only by unlock; RQ4 software may clear but never set, set wins
    assign ew_en_nxt = unlock_ok ? 1'b1 :
                       (wr_ctrl && !reg_wdata[iapfpc_pkg::BIT_EW_ENABLED]) ? 1'b0 :
                       ew_en_r;

    // ----------------------------------------------------------------
    // operation launch
    // ----------------------------------------------------------------
    assign mode_nxt = wr_ctrl ? reg_wdata[iapfpc_pkg::BIT_MODE_HI:iapfpc_pkg::BIT_MODE_LO] : mode_r;
    wire idle = (state_r == ST_IDLE);
    // RQ10 write or erase launch, only once unlocked (a start without unlock is dropped)
    wire launch_write = wr_ctrl && reg_wdata[iapfpc_pkg::BIT_WRITE_START] && idle &&
                        ew_en_r && is_prog_mode(mode_nxt);
    // RQ11 read needs read_enable already set by an earlier access
    wire launch_read = wr_ctrl && reg_wdata[iapfpc_pkg::BIT_READ_START] && idle &&
                       read_enable_r && (mode_nxt == iapfpc_pkg::MODE_READ) && !launch_write;
    wire op_done = (state_r == ST_BUSY) && flash_done;
    wire write_done = op_done && (cmd_r.op == iapfpc_pkg::OP_WRITE);
    wire read_done = op_done && (cmd_r.op == iapfpc_pkg::OP_READ);

    // RQ6 mode decode to array operation
    assign op_nxt = (mode_nxt == iapfpc_pkg::MODE_ERASE) ? iapfpc_pkg::OP_ERASE :
                    (mode_nxt == iapfpc_pkg::MODE_WRITE) ? iapfpc_pkg::OP_WRITE :
                    iapfpc_pkg::OP_READ;
    assign cmd_nxt = {op_nxt, addr_r};

    // RQ10 start bit cleared on completion
    assign write_start_nxt = launch_write ? 1'b1 :
                             (op_done && cmd_r.op != iapfpc_pkg::OP_READ) ? 1'b0 :
                             write_start_r;
    // RQ12 start bit cleared on completion
    assign read_start_nxt = launch_read ? 1'b1 : read_done ? 1'b0 : read_start_r;

    // clear request stands one cycle while the buffer is wiped
    assign clear_write_buffer_nxt = (wr_bufc && reg_wdata[iapfpc_pkg::BIT_CLEAR_BUFFER]) ? 1'b1 : 1'b0;
    // RQ19 buffer wiped after a write as well as on request
    wire buf_clear = clear_write_buffer_r || write_done;
    // RQ3 buffer load on the high byte, only with erase/write unlocked
    wire buf_load = wr_d0h && ew_en_r;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    wire [7:0] ctrl_view = {ew_en_r, mode_r, trigger_r, write_start_r, read_enable_r,
                            read_start_r};
    always_comb begin
        case (reg_addr)
            iapfpc_pkg::OFS_ADDR_LOW: rd_sel = addr_r[7:0];
            iapfpc_pkg::OFS_ADDR_HIGH: rd_sel = {3'h0, addr_r[12:8]};
            iapfpc_pkg::OFS_DATA0_LOW: rd_sel = data_lo_r[0];
            iapfpc_pkg::OFS_DATA0_HIGH: rd_sel = data_hi_r[0];
            iapfpc_pkg::OFS_DATA1_LOW: rd_sel = data_lo_r[1];
            iapfpc_pkg::OFS_DATA1_HIGH: rd_sel = data_hi_r[1];
            iapfpc_pkg::OFS_DATA2_LOW: rd_sel = data_lo_r[2];
            iapfpc_pkg::OFS_DATA2_HIGH: rd_sel = data_hi_r[2];
            iapfpc_pkg::OFS_DATA3_LOW: rd_sel = data_lo_r[3];
            iapfpc_pkg::OFS_DATA3_HIGH: rd_sel = data_hi_r[3];
            iapfpc_pkg::OFS_PROGRAM_CONTROL: rd_sel = ctrl_view;
            iapfpc_pkg::OFS_CHIP_RESET_KEY: rd_sel = chip_key_r;
            iapfpc_pkg::OFS_BUFFER_CONTROL: rd_sel = {7'h00, clear_write_buffer_r};
            default: rd_sel = iapfpc_pkg::RESET_BYTE;
        endcase
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_r <= 13'h0000;
            ew_en_r <= 1'b0;
            mode_r <= 3'h0;
            trigger_r <= 1'b0;
            write_start_r <= 1'b0;
            read_enable_r <= 1'b0;
            read_start_r <= 1'b0;
            clear_write_buffer_r <= 1'b0;
            key_seen_r <= 6'h00;
            chip_key_r <= iapfpc_pkg::RESET_BYTE;
        end else begin
            addr_r <= addr_nxt;
            ew_en_r <= ew_en_nxt;
            mode_r <= mode_nxt;
            trigger_r <= trigger_nxt;
            write_start_r <= write_start_nxt;
            read_enable_r <= wr_ctrl ? reg_wdata[iapfpc_pkg::BIT_READ_ENABLE] : read_enable_r;
            read_start_r <= read_start_nxt;
            clear_write_buffer_r <= clear_write_buffer_nxt;
            key_seen_r <= key_seen_nxt;
            chip_key_r <= wr_chip ? reg_wdata : chip_key_r;
        end
    end

    // RQ8 window counter
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_r <= 16'h0000;
        end else if (trigger_start) begin
            timer_r <= UNLOCK_LOAD;
        end else if (trigger_r) begin
            timer_r <= timer_r - iapfpc_pkg::TIMER_LAST;
        end
    end

    // RQ16 chip reset pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            chip_reset_r <= 1'b0;
        end else begin
            chip_reset_r <= wr_chip && (reg_wdata == iapfpc_pkg::CHIP_RESET_PATTERN);
        end
    end

    // ----------------------------------------------------------------
    // data registers
    // ----------------------------------------------------------------
    // RQ2 low byte only stores; a finished read returns its word into pair zero
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < iapfpc_pkg::DATA_PAIRS; i++) begin
                data_lo_r[i] <= iapfpc_pkg::RESET_BYTE;
                data_hi_r[i] <= iapfpc_pkg::RESET_BYTE;
            end
        end else begin
            for (int i = 0; i < iapfpc_pkg::DATA_PAIRS; i++) begin
                if (wr_lo_vec[i]) begin
                    data_lo_r[i] <= reg_wdata;
                end
                if (wr_hi_vec[i]) begin
                    data_hi_r[i] <= reg_wdata;
                end
            end
            if (read_done) begin
                data_lo_r[0] <= flash_rdata[7:0];
                data_hi_r[0] <= flash_rdata[15:8];
            end
        end
    end

    // ----------------------------------------------------------------
    // write buffer
    // ----------------------------------------------------------------
    // full wipe in one cycle costs flops but keeps software polling to one read
    always_ff @(posedge clk) begin
        if (rst || buf_clear) begin
            for (int i = 0; i < iapfpc_pkg::BUF_DEPTH; i++) begin
                wbuf[i] <= 16'h0000;
            end
        end
        // RQ3 combined word goes into the slot of the current address
        if (!rst && buf_load) begin
            wbuf[addr_r[iapfpc_pkg::BUF_IDX_W-1:0]] <= {reg_wdata, data_lo_r[0]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            buf_rd_r <= 16'h0000;
        end else begin
            buf_rd_r <= wbuf[buf_rd_idx];
        end
    end

    // ----------------------------------------------------------------
    // operation sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cmd_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (launch_write || launch_read) begin
                        state_r <= ST_BUSY;
                        cmd_r <= cmd_nxt;
                    end
                end
                ST_BUSY: begin
                    if (flash_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read data and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= iapfpc_pkg::RESET_BYTE;
        end else begin
            rdata_r <= reg_re ? rd_sel : iapfpc_pkg::RESET_BYTE;
        end
    end

    assign reg_rdata = rdata_r;
    assign flash_cmd = cmd_r;
    assign flash_req = (state_r == ST_BUSY);
    // RQ14 processor held for the whole operation
    assign cpu_stall = (state_r == ST_BUSY);
    assign chip_reset = chip_reset_r;
    assign buf_rd_data = buf_rd_r;

endmodule

/* File: design/iapfpc_pkg.sv */
// constants, field layout and carrier types for the flash programming control block
package iapfpc_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_ADDR_LOW = 4'h0;
    localparam logic [3:0] OFS_ADDR_HIGH = 4'h1;
    localparam logic [3:0] OFS_DATA0_LOW = 4'h2;
    localparam logic [3:0] OFS_DATA0_HIGH = 4'h3;
    localparam logic [3:0] OFS_DATA1_LOW = 4'h4;
    localparam logic [3:0] OFS_DATA1_HIGH = 4'h5;
    localparam logic [3:0] OFS_DATA2_LOW = 4'h6;
    localparam logic [3:0] OFS_DATA2_HIGH = 4'h7;
    localparam logic [3:0] OFS_DATA3_LOW = 4'h8;
    localparam logic [3:0] OFS_DATA3_HIGH = 4'h9;
    localparam logic [3:0] OFS_PROGRAM_CONTROL = 4'hA;
    localparam logic [3:0] OFS_CHIP_RESET_KEY = 4'hB;
    localparam logic [3:0] OFS_BUFFER_CONTROL = 4'hC;

    // ----------------------------------------------------------------
    // field positions and widths
    // ----------------------------------------------------------------
    localparam int BIT_EW_ENABLED = 7;
    localparam int BIT_MODE_HI = 6;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_UNLOCK_TRIGGER = 3;
    localparam int BIT_WRITE_START = 2;
    localparam int BIT_READ_ENABLE = 1;
    localparam int BIT_READ_START = 0;
    localparam int BIT_CLEAR_BUFFER = 0;
    localparam int ADDR_HIGH_W = 5;
    localparam int WORD_ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int BUF_DEPTH = 32;
    localparam int BUF_IDX_W = 5;
    localparam int KEY_REGS = 6;
    localparam int DATA_PAIRS = 4;
    localparam int TIMER_W = 16;

    // ----------------------------------------------------------------
    // values
    // ----------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] CHIP_RESET_PATTERN = 8'h55;
    localparam logic [4:0] PAGE_LAST = 5'h1F;
    localparam logic [12:0] ADDR_STEP = 13'h0001;
    localparam logic [15:0] TIMER_LAST = 16'h0001;
    localparam logic [2:0] MODE_WRITE = 3'h0;
    localparam logic [2:0] MODE_ERASE = 3'h1;
    localparam logic [2:0] MODE_READ = 3'h3;
    localparam logic [2:0] MODE_UNLOCK = 3'h6;
    // unlock key, order: data1_low, data2_low, data3_low, data1_high, data2_high, data3_high
    localparam logic [7:0] KEY_DATA1_LOW = 8'h00;
    localparam logic [7:0] KEY_DATA2_LOW = 8'h0D;
    localparam logic [7:0] KEY_DATA3_LOW = 8'hC3;
    localparam logic [7:0] KEY_DATA1_HIGH = 8'h04;
    localparam logic [7:0] KEY_DATA2_HIGH = 8'h09;
    localparam logic [7:0] KEY_DATA3_HIGH = 8'h40;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int UNLOCK_TIME_NS_DEFAULT = 10000;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_WRITE,
        OP_ERASE,
        OP_READ
    } iapfpc_op_type;

    typedef struct packed {
        iapfpc_op_type op;
        logic [12:0] word_address;
    } iapfpc_cmd_type;

endpackage

/* File: tb/iapfpc_asserts.sv */
// assertion checker for the flash programming control block
`timescale 1ns/1ns
module iapfpc_asserts #(
    parameter int UNLOCK_TIME_NS = iapfpc_pkg::UNLOCK_TIME_NS_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_rdata,
    // flash array side
    input wire iapfpc_pkg::iapfpc_cmd_type flash_cmd,
    input wire logic flash_req,
    input wire logic flash_done,
    // system
    input wire logic cpu_stall,
    input wire logic chip_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // idle control write: the only cause of a launch
    sequence s_ctrl_wr;
        reg_we && reg_addr == iapfpc_pkg::OFS_PROGRAM_CONTROL && !flash_req;
    endsequence
    sequence s_key_wr;
        reg_we && reg_addr == iapfpc_pkg::OFS_CHIP_RESET_KEY && reg_wdata == 8'h55;
    endsequence
    property p_stall; flash_req == cpu_stall; endproperty
    property p_high_zero; reg_re && reg_addr == 4'h1 |=> reg_rdata[7:5] == 3'h0; endproperty
    property p_reset_pulse; s_key_wr |=> chip_reset ##1 !chip_reset; endproperty
    property p_reset_cause; chip_reset |-> $past(reg_we) && $past(reg_wdata) == 8'h55; endproperty
    property p_reserved;
        s_ctrl_wr ##0 reg_wdata[6:4] inside {3'h2, 3'h4, 3'h5, 3'h6, 3'h7} |=> !flash_req;
    endproperty
    property p_launch_src; $rose(flash_req) |-> $past(reg_we && reg_addr == 4'hA); endproperty
    property p_read_op;
        $rose(flash_req) && $past(reg_wdata[6:4]) == 3'h3 |-> flash_cmd.op == iapfpc_pkg::OP_READ;
    endproperty
    property p_erase_op;
        $rose(flash_req) && $past(reg_wdata[6:4]) == 3'h1 |-> flash_cmd.op == iapfpc_pkg::OP_ERASE;
    endproperty
    property p_done_end; flash_req && flash_done |=> !flash_req; endproperty
    property p_busy_hold; flash_req && !flash_done |=> flash_req && $stable(flash_cmd); endproperty
    a_stall: assert property (p_stall)
        else $error("stall differs from request");
    a_high_zero: assert property (p_high_zero)
        else $error("address high upper bits not zero");
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("chip reset pulse wrong");
    a_reset_cause: assert property (p_reset_cause)
        else $error("chip reset without pattern");
    a_reserved: assert property (p_reserved)
        else $error("launch in reserved mode");
    a_launch_src: assert property (p_launch_src)
        else $error("launch without control write");
    a_read_op: assert property (p_read_op)
        else $error("read launch wrong op");
    a_erase_op: assert property (p_erase_op)
        else $error("erase launch wrong op");
    a_done_end: assert property (p_done_end)
        else $error("busy after done");
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped or command changed");
endmodule
bind iapfpc_top iapfpc_asserts #(.UNLOCK_TIME_NS(UNLOCK_TIME_NS)) iapfpc_asserts_inst (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .flash_cmd(flash_cmd), .flash_req(flash_req),
    .flash_done(flash_done), .cpu_stall(cpu_stall), .chip_reset(chip_reset));

/* File: tb/iapfpc_test.sv */
// self-checking bench for the flash programming control block
`timescale 1ns/1ns
module iapfpc_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic flash_done = 1'b0;
    logic [15:0] flash_rdata = 16'h0000;
    logic [4:0] buf_rd_idx = 5'h00;
    logic [7:0] reg_rdata;
    iapfpc_pkg::iapfpc_cmd_type flash_cmd;
    logic flash_req;
    logic cpu_stall;
    logic chip_reset;
    logic [15:0] buf_rd_data;
    int miscompares = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    // short unlock window: 20 cycles keeps the run brief
    iapfpc_top #(.UNLOCK_TIME_NS(200)) iapfpc_top_inst (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .flash_cmd(flash_cmd), .flash_req(flash_req),
        .flash_done(flash_done), .flash_rdata(flash_rdata), .buf_rd_idx(buf_rd_idx),
        .buf_rd_data(buf_rd_data), .cpu_stall(cpu_stall), .chip_reset(chip_reset));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge clk);
        reg_re <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask
    task automatic chkbuf(input logic [4:0] i, input logic [15:0] exp);
        @(posedge clk);
        buf_rd_idx <= i;
        @(posedge clk);
        #1;
        chk(buf_rd_data, exp);
    endtask
    // key bytes in key order, lows then highs; last byte lets a scenario spoil the pattern
    task automatic keys(input logic [7:0] last);
        wr(4'h4, 8'h00);
        wr(4'h6, 8'h0D);
        wr(4'h8, 8'hC3);
        wr(4'h5, 8'h04);
        wr(4'h7, 8'h09);
        wr(4'h9, last);
    endtask
    // operation already launched by the last write; finish it from the array side
    task automatic op(input logic [1:0] o, input logic [15:0] d);
        #1;
        chk({15'h0, cpu_stall}, 16'h0001);
        chk({14'h0, flash_cmd.op}, {14'h0, o});
        chk({3'h0, flash_cmd.word_address}, 16'h011F);
        @(posedge clk);
        flash_rdata <= d;
        flash_done <= 1'b1;
        @(posedge clk);
        flash_done <= 1'b0;
        #1;
        chk({15'h0, flash_req}, 16'h0000);
    endtask
    task automatic s_unlock();
        wr(4'hA, 8'h68);
        keys(8'h41);
        rd(4'hA, 8'h68);
        repeat (20) @(posedge clk);
        rd(4'hA, 8'h60);
        keys(8'h40);
        rd(4'hA, 8'h60);
        wr(4'hA, 8'h80);
        rd(4'hA, 8'h00);
        wr(4'hA, 8'h68);
        keys(8'h40);
        rd(4'hA, 8'hE8);
        repeat (20) @(posedge clk);
        rd(4'hA, 8'hE0);
    endtask
    task automatic s_load();
        wr(4'h0, 8'h1E);
        wr(4'h1, 8'hE1);
        rd(4'h1, 8'h01);
        wr(4'h2, 8'h34);
        chkbuf(5'h1E, 16'h0000);
        wr(4'h3, 8'h12);
        chkbuf(5'h1E, 16'h1234);
        rd(4'h0, 8'h1F);
        wr(4'h2, 8'h78);
        wr(4'h3, 8'h56);
        rd(4'h0, 8'h1F);
        chkbuf(5'h1F, 16'h5678);
    endtask
    task automatic s_ops();
        wr(4'hA, 8'h84);
        op(iapfpc_pkg::OP_WRITE, 16'h0000);
        rd(4'hA, 8'h80);
        chkbuf(5'h1E, 16'h0000);
        wr(4'hA, 8'h94);
        op(iapfpc_pkg::OP_ERASE, 16'h0000);
        wr(4'hA, 8'hA4);
        #1 chk({15'h0, flash_req}, 16'h0000);
        wr(4'h3, 8'hAA);
        chkbuf(5'h1F, 16'hAA78);
        wr(4'hC, 8'h01);
        chkbuf(5'h1F, 16'h0000);
        wr(4'hA, 8'h00);
        rd(4'hA, 8'h00);
        wr(4'hA, 8'h04);
        #1 chk({15'h0, flash_req}, 16'h0000);
        wr(4'hA, 8'h31);
        #1 chk({15'h0, flash_req}, 16'h0000);
        wr(4'hA, 8'h32);
        wr(4'hA, 8'h33);
        op(iapfpc_pkg::OP_READ, 16'hBEEF);
        rd(4'hA, 8'h32);
        rd(4'h2, 8'hEF);
        rd(4'h3, 8'hBE);
    endtask
    task automatic s_chip_reset();
        wr(4'hD, 8'hFF);
        rd(4'hD, 8'h00);
        wr(4'hB, 8'h54);
        #1 chk({15'h0, chip_reset}, 16'h0000);
        rd(4'hB, 8'h54);
        wr(4'hB, 8'h55);
        #1 chk({15'h0, chip_reset}, 16'h0001);
        @(posedge clk);
        #1 chk({15'h0, chip_reset}, 16'h0000);
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            rd(4'(i), 8'h00);
        end
        s_unlock();
        s_load();
        s_ops();
        s_chip_reset();
        end_sim();
    end
endmodule
